// [logic/wdc_pkg.sv]
// shared constants and types of the watchdog timer control block
package wdc_pkg;

  // ----------------------------------------------------------------
  // control register layout
  // ----------------------------------------------------------------
  // msb to lsb: period select, irq select, status, enable, write unlock
  typedef struct packed {
    logic [3:0] period_sel;
    logic timeout_irq_select;
    logic status;
    logic enable;
    logic control_write_unlock;
  } wdc_ctrl_type;

  localparam wdc_ctrl_type CTRL_RESET = 8'h00;
  localparam int CTRL_W = 8;
  localparam int PSEL_W = 4;
  // control byte that selects the two second period, reset mode, enabled
  localparam logic [CTRL_W-1:0] CTRL_TWO_SEC = 8'h72;
  // period select code of the 31.2 ms step
  localparam logic [PSEL_W-1:0] PSEL_CODE1 = 4'h1;
  // period in base units for code 7 and for code 1
  localparam longint TWO_SEC_SCALE = 64'd128;
  localparam longint CODE1_SCALE = 64'd2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  // shortest period (code 0) is 15.625 ms; each code step doubles it
  localparam longint BASE_PERIOD_NS = 64'd15625000;
  localparam longint CLK_PERIOD_NS = 64'd4;
  localparam int BASE_CYCLES = int'(BASE_PERIOD_NS / CLK_PERIOD_NS);
  localparam int CNT_W = 40;

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_OFF = 2'b01,
    ST_RUN = 2'b10
  } wdc_state_type;

endpackage : wdc_pkg

// [logic/wdc_watchdog.sv]
// watchdog timer with unlock-protected control register and status flag
// Overview of operation
// - timeout sets the watchdog status flag
// - flag cleared only by zero write or reset
// - watchdog reset leaves the status flag set
// - enabled timeout resets or interrupts per mode
// - value 72h enables two second timeout
module wdc_watchdog #(
  parameter int BASE_CYCLES = wdc_pkg::BASE_CYCLES
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // control register access from the core
  input wire logic UNLOCK_SET,
  input wire logic CTRL_WR,
  input wire logic [7:0] CTRL_WDATA,
  input wire logic INSTR_STEP,
  output logic [7:0] CTRL_RDATA,
  // timeout responses
  output logic STATUS_FLAG,
  output logic WDT_RESET,
  output logic WDT_IRQ
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  wdc_pkg::wdc_ctrl_type ctrl_r;
  wdc_pkg::wdc_ctrl_type ctrl_nxt;
  wdc_pkg::wdc_state_type state_r;
  wdc_pkg::wdc_state_type state_nxt;
  logic [wdc_pkg::CNT_W-1:0] cnt_r;
  logic [wdc_pkg::CNT_W-1:0] cnt_nxt;
  logic rst_pulse_r;
  logic irq_pulse_r;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire wdc_pkg::wdc_ctrl_type wr_val = wdc_pkg::wdc_ctrl_type'(CTRL_WDATA);
  // write accepted only right after unlock
  wire logic wr_ok = CTRL_WR && ctrl_r.control_write_unlock;
  // plain write of zero to status, allowed without unlock
  wire logic clr_stat = CTRL_WR && !ctrl_r.control_write_unlock && !wr_val.status;
  // unlock opens only when no write shares its cycle
  wire logic unlock_arm = UNLOCK_SET && !CTRL_WR;
  // any write or other retired instruction closes the window
  wire logic unlock_drop = CTRL_WR || INSTR_STEP;
  // period = base << code; code 1 -> 31.2 ms, code 7 -> 2.0 s
  // 40 bits hold the base shifted by the top code without wrapping
  wire logic [wdc_pkg::CNT_W-1:0] period =
    wdc_pkg::CNT_W'(BASE_CYCLES) << ctrl_r.period_sel;
  wire logic expire = (state_r == wdc_pkg::ST_RUN) && (cnt_r == period - 1'b1);
  wire logic do_reset = expire && !ctrl_r.timeout_irq_select;
  wire logic do_irq = expire && ctrl_r.timeout_irq_select;

  // ----------------------------------------------------------------
  // next control value
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ok) begin
      ctrl_nxt = wr_val;
      // a write may keep or clear the flag, never set it
      ctrl_nxt.status = wr_val.status && ctrl_r.status;
    end else if (clr_stat) begin
      ctrl_nxt.status = 1'b0;
    end
    // unlock lasts one instruction only
    if (unlock_arm) begin
      ctrl_nxt.control_write_unlock = 1'b1;
    end else if (unlock_drop) begin
      ctrl_nxt.control_write_unlock = 1'b0;
    end
    // own reset drops enable but keeps the flag
    // it beats a write in the same cycle, as the device restarts anyway
    if (do_reset) begin
      ctrl_nxt.enable = 1'b0;
    end
    // set wins over clear
    if (expire) begin
      ctrl_nxt.status = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // counter and state
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r + 1'b1;
    case (state_r)
      wdc_pkg::ST_OFF: begin
        // parked at zero so the next enable starts a full period
        cnt_nxt = '0;
        if (ctrl_nxt.enable) begin
          state_nxt = wdc_pkg::ST_RUN;
        end
      end
      wdc_pkg::ST_RUN: begin
        if (!ctrl_nxt.enable) begin
          state_nxt = wdc_pkg::ST_OFF;
          cnt_nxt = '0;
        end else if (wr_ok || expire) begin
          cnt_nxt = '0; // refresh or next period
        end
      end
      default: begin
        state_nxt = wdc_pkg::ST_OFF;
        cnt_nxt = '0;
      end
    endcase
  end

  // registers
  // only RST_N clears the flag here; WDT_RESET leaves this block alone
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_r <= wdc_pkg::CTRL_RESET;
      state_r <= wdc_pkg::ST_OFF;
      cnt_r <= '0;
      rst_pulse_r <= 1'b0;
      irq_pulse_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      rst_pulse_r <= do_reset;
      irq_pulse_r <= do_irq;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign CTRL_RDATA = ctrl_r;
  assign STATUS_FLAG = ctrl_r.status;
  assign WDT_RESET = rst_pulse_r;
  assign WDT_IRQ = irq_pulse_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_flag_on_expire: assert property (@(posedge MCLK) disable iff (!RST_N)
    expire |=> STATUS_FLAG)
    else $error("status flag not set on timeout");

  a_flag_clear_cause: assert property (@(posedge MCLK) disable iff (!RST_N)
    ($past(STATUS_FLAG) && !STATUS_FLAG) |-> $past(CTRL_WR) && !$past(wr_val.status))
    else $error("status flag cleared without a zero write");

  a_flag_after_wreset: assert property (@(posedge MCLK) disable iff (!RST_N)
    WDT_RESET |-> STATUS_FLAG && !ctrl_r.enable)
    else $error("watchdog reset lost the flag or kept enable");

  a_mode_response: assert property (@(posedge MCLK) disable iff (!RST_N)
    expire |=> (WDT_IRQ == $past(ctrl_r.timeout_irq_select)) && (WDT_RESET != WDT_IRQ))
    else $error("timeout response does not match mode");

  a_locked_write: assert property (@(posedge MCLK) disable iff (!RST_N)
    (CTRL_WR && !ctrl_r.control_write_unlock && !expire) |=> $stable(ctrl_r.period_sel)
      && $stable(ctrl_r.timeout_irq_select) && $stable(ctrl_r.enable))
    else $error("control changed without unlock");

  a_two_second: assert property (@(posedge MCLK) disable iff (!RST_N)
    (wr_ok && CTRL_WDATA == wdc_pkg::CTRL_TWO_SEC) |=> ctrl_r.enable
      && state_r == wdc_pkg::ST_RUN
      && period == wdc_pkg::CNT_W'(BASE_CYCLES) * wdc_pkg::CNT_W'(wdc_pkg::TWO_SEC_SCALE))
    else $error("72h did not start a two second period");

  a_period_double: assert property (@(posedge MCLK) disable iff (!RST_N)
    (ctrl_r.period_sel == wdc_pkg::PSEL_CODE1)
      |-> period == wdc_pkg::CNT_W'(BASE_CYCLES) * wdc_pkg::CNT_W'(wdc_pkg::CODE1_SCALE))
    else $error("code 1 period is not twice the base");

  // ----------------------------------------------------------------
  // checks on the unlock window, flag, responses, state and counter
  // ----------------------------------------------------------------
  a_unlock_arms: assert property (@(posedge MCLK) disable iff (!RST_N)
    (UNLOCK_SET && !CTRL_WR) |=> ctrl_r.control_write_unlock)
    else $error("unlock request did not open the write window");

  a_unlock_one_shot: assert property (@(posedge MCLK) disable iff (!RST_N)
    (CTRL_WR || (INSTR_STEP && !UNLOCK_SET)) |=> !ctrl_r.control_write_unlock)
    else $error("write window outlived the next instruction");

  a_flag_zero_write: assert property (@(posedge MCLK) disable iff (!RST_N)
    (CTRL_WR && !wr_val.status && !expire) |=> !STATUS_FLAG)
    else $error("zero write did not clear the status flag");

  a_single_response: assert property (@(posedge MCLK) disable iff (!RST_N)
    !(WDT_RESET && WDT_IRQ))
    else $error("reset and interrupt raised together");

  a_reset_stops: assert property (@(posedge MCLK) disable iff (!RST_N)
    (expire && !ctrl_r.timeout_irq_select) |=> state_r == wdc_pkg::ST_OFF)
    else $error("counting went on after a watchdog reset");

  a_irq_keeps_run: assert property (@(posedge MCLK) disable iff (!RST_N)
    (expire && ctrl_r.timeout_irq_select && !CTRL_WR)
      |=> state_r == wdc_pkg::ST_RUN && cnt_r == '0)
    else $error("interrupt mode did not start the next period");

  a_count_bound: assert property (@(posedge MCLK) disable iff (!RST_N)
    (state_r == wdc_pkg::ST_RUN) |-> cnt_r < period)
    else $error("count ran past the selected period");

  a_state_onehot: assert property (@(posedge MCLK) disable iff (!RST_N)
    $onehot(state_r))
    else $error("state left its one-hot codes");

  a_enable_state: assert property (@(posedge MCLK) disable iff (!RST_N)
    ctrl_r.enable == (state_r == wdc_pkg::ST_RUN))
    else $error("enable bit and counting state disagree");

  a_write_restart: assert property (@(posedge MCLK) disable iff (!RST_N)
    wr_ok |=> cnt_r == '0)
    else $error("accepted write did not restart the count");

endmodule : wdc_watchdog

// [dv/test_wdc_watchdog.sv]
// self-checking bench of the watchdog timer control block
module test_wdc_watchdog;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // signals and counters
  // ----------------------------------------------------------------
  logic MCLK = 1'b0;
  logic RST_N = 1'b0;
  logic UNLOCK_SET = 1'b0;
  logic CTRL_WR = 1'b0;
  logic INSTR_STEP = 1'b0;
  logic [7:0] CTRL_WDATA = 8'h00;
  logic [7:0] CTRL_RDATA;
  logic STATUS_FLAG, WDT_RESET, WDT_IRQ;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int n;
  // one row: control byte, cycles to expiry, interrupt mode
  typedef struct packed {logic [7:0] d; logic [15:0] per; logic irq;} wdc_row_type;
  wdc_row_type rows[4] = '{'{8'h0a, 16'd4, 1'b1}, '{8'h12, 16'd8, 1'b0},
                           '{8'h2a, 16'd16, 1'b1}, '{8'h72, 16'd512, 1'b0}};

  // short periods so every code in rows (0, 1, 2 and 7) fits the run
  wdc_watchdog #(.BASE_CYCLES(4)) u_wdc_watchdog (.MCLK(MCLK), .RST_N(RST_N),
    .UNLOCK_SET(UNLOCK_SET), .CTRL_WR(CTRL_WR), .CTRL_WDATA(CTRL_WDATA),
    .INSTR_STEP(INSTR_STEP), .CTRL_RDATA(CTRL_RDATA), .STATUS_FLAG(STATUS_FLAG),
    .WDT_RESET(WDT_RESET), .WDT_IRQ(WDT_IRQ));

  // clock and hang guard
  always #2 MCLK = ~MCLK;
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task tick;
    @(posedge MCLK);
    #1;
  endtask : tick
  // control write, optionally after the unlock pulse
  task wr(input logic [7:0] d, input logic unl);
    if (unl) begin
      UNLOCK_SET = 1'b1;
      tick();
      UNLOCK_SET = 1'b0;
    end
    // write follows the unlock at once, nothing can fall between
    CTRL_WR = 1'b1;
    CTRL_WDATA = d;
    tick();
    CTRL_WR = 1'b0;
  endtask : wr
  // enable, time the expiry, check the response
  task run(input wdc_row_type r);
    wr(r.d, 1'b1);
    chk(CTRL_RDATA, r.d);
    n = 0;
    while (!(WDT_IRQ | WDT_RESET) && n < 2000) begin
      tick();
      n++;
    end
    chk(16'(n), r.per);
    chk({WDT_IRQ, WDT_RESET, STATUS_FLAG}, {r.irq, !r.irq, 1'b1});
    chk(CTRL_RDATA, r.irq ? (r.d | 8'h04) : ((r.d & 8'hfd) | 8'h04));
    tick();
    chk({WDT_IRQ, WDT_RESET, STATUS_FLAG}, 3'b001);
  endtask : run
  task conclude;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge MCLK);
    #1;
    chk({CTRL_RDATA, STATUS_FLAG, WDT_RESET, WDT_IRQ}, 11'h000);
    RST_N = 1'b1;
    tick();
    foreach (rows[i]) run(rows[i]);
    // locked write and a broken unlock sequence are refused
    wr(8'h0e, 1'b0);
    chk(CTRL_RDATA, 8'h74);
    UNLOCK_SET = 1'b1;
    tick();
    UNLOCK_SET = 1'b0;
    INSTR_STEP = 1'b1;
    tick();
    INSTR_STEP = 1'b0;
    wr(8'h0e, 1'b0);
    chk(CTRL_RDATA, 8'h74);
    // unlock and write in one cycle leave the register locked
    tick();
    UNLOCK_SET = 1'b1;
    wr(8'h0e, 1'b0);
    UNLOCK_SET = 1'b0;
    chk(CTRL_RDATA, 8'h74);
    tick();
    wr(8'h0e, 1'b0);
    chk(CTRL_RDATA, 8'h74);
    // hardware reset clears a set flag
    RST_N = 1'b0;
    tick();
    chk(STATUS_FLAG, 1'b0);
    RST_N = 1'b1;
    tick();
    run('{8'h02, 16'd4, 1'b0});
    // zero written to the flag clears it while locked
    wr(8'h00, 1'b0);
    chk({CTRL_RDATA, STATUS_FLAG}, 9'h000);
    // a zero write in the expiry cycle loses to the timeout
    wr(8'h0a, 1'b1);
    repeat (3) tick();
    wr(8'h00, 1'b0);
    chk({WDT_IRQ, STATUS_FLAG}, 2'b11);
    tick();
    wr(8'h00, 1'b0);
    chk(STATUS_FLAG, 1'b0);
    conclude();
  end
endmodule : test_wdc_watchdog
